// >>> rtl/icr_clear_regs.sv
// Read-to-clear interrupt register set of the second bus controller
// Summary of operation
// RL1: Clear-all read clears flags and cause, keeping set cause bit 9
// RL2: Clear-all spares hardware-cleared threshold flags
// RL3: Underflow clear read resets status bit 0
// RL4: Overflow clear read resets status bit 1
// RL5: Transmit overflow clear resets status bit 3
// RL6: Read-request clear resets status bit 5
// RL7: Abort clear resets bit 6 and cause, keeping set cause bit 9
// RL8: Abort clear read releases flushed transmit FIFO
// RL9: Receive-done clear resets status bit 7
// RL10: Busy clear works only when bus idle
// RL11: Busy flag stays set while bus engaged
// RL12: Hardware clears busy when disabled and idle
// RL13: Busy clear read returns busy flag
// RL14: Transmit FIFO stays flushed until abort clear or clear-all read
// RL15: Stop clear read resets stop-detect flag
// RL16: Status in bit 0, zero above; writes ignored
`timescale 1ns/1ns
module icr_clear_regs #(
	parameter int FLAG_W  = icr_pkg::FLAG_W,
	parameter int CAUSE_W = icr_pkg::CAUSE_W
) (
	input  wire logic               mclk_in,
	input  wire logic               reset_n_in,
	input  wire logic [31:0]        addr_in,
	input  wire logic               read_in,
	input  wire logic               write_in,
	input  wire logic [15:0]        wdata_in,
	output logic      [15:0]        rdata_out,
	input  wire logic [FLAG_W-1:0]  flag_set_in,
	input  wire logic               rx_full_level_in,
	input  wire logic               tx_empty_level_in,
	input  wire logic [CAUSE_W-1:0] abort_cause_set_in,
	input  wire logic               ctrl_enable_in,
	input  wire logic               bus_active_in,
	output logic      [FLAG_W-1:0]  raw_interrupt_status_out,
	output logic      [CAUSE_W-1:0] transmit_abort_cause_out,
	output logic                    combined_irq_out,
	output logic                    tx_fifo_flush_out
);
	icr_pkg::icr_sel_t sel;
	logic [FLAG_W-1:0]  flags;
	logic [FLAG_W-1:0]  spare_flags;
	logic               rx_under_flag;
	logic               rx_over_flag;
	logic               rx_full_flag;
	logic               tx_over_flag;
	logic               tx_empty_flag;
	logic               read_req_flag;
	logic               transmit_abort_flag;
	logic               rx_done_flag;
	logic               bus_busy_flag;
	logic               stop_detected_flag;
	logic               start_seen_flag;
	logic               general_call_flag;
	logic               busy_self_clear;
	logic [FLAG_W-1:0]  clr_mask;
	logic [CAUSE_W-1:0] cause;
	logic [CAUSE_W-1:0] next_cause;
	logic               flush_hold;
	logic               cause_clear;
	logic               busy_idle;
	logic               rd_bit;
	logic               unused_write;

	// Writes to these read-only registers are dropped
	assign unused_write = write_in ^ (|wdata_in);  // RL16

	icr_decode u_decode (
		.addr_in (addr_in),
		.read_in (read_in),
		.sel_out (sel)
	);

	// Single bit mask helper
	function automatic logic [FLAG_W-1:0] bit_of(input int pos);
		logic [FLAG_W-1:0] m;
		m = '0;
		m[pos] = 1'b1;
		return m;
	endfunction

	// Bus idle when neither enabled engine still works
	assign busy_idle = !bus_active_in;

	// Which flags the current read clears
	always_comb begin
		clr_mask = '0;
		cause_clear = 1'b0;
		case (sel)
			icr_pkg::ICR_SEL_ALL: begin
				// Threshold flags are left to hardware
				clr_mask = icr_pkg::SW_CLEAR_MASK[FLAG_W-1:0];  // RL1 RL2
				if (!busy_idle)
					clr_mask[icr_pkg::BIT_BUSY] = 1'b0;  // RL11
				cause_clear = 1'b1;  // RL1
			end
			icr_pkg::ICR_SEL_RXU:
				clr_mask = bit_of(icr_pkg::BIT_RX_UNDER);  // RL3
			icr_pkg::ICR_SEL_RXO:
				clr_mask = bit_of(icr_pkg::BIT_RX_OVER);  // RL4
			icr_pkg::ICR_SEL_TXO:
				clr_mask = bit_of(icr_pkg::BIT_TX_OVER);  // RL5
			icr_pkg::ICR_SEL_RDQ:
				clr_mask = bit_of(icr_pkg::BIT_RD_REQ);  // RL6
			icr_pkg::ICR_SEL_TXA: begin
				clr_mask = bit_of(icr_pkg::BIT_TX_ABORT);  // RL7
				cause_clear = 1'b1;  // RL7
			end
			icr_pkg::ICR_SEL_RXD:
				clr_mask = bit_of(icr_pkg::BIT_RX_DONE);  // RL9
			icr_pkg::ICR_SEL_BUSY: begin
				// Ignored while still engaged on the bus
				if (busy_idle)
					clr_mask = bit_of(icr_pkg::BIT_BUSY);  // RL10 RL11
			end
			icr_pkg::ICR_SEL_STOP:
				clr_mask = bit_of(icr_pkg::BIT_STOP);  // RL15
			default:
				clr_mask = '0;
		endcase
	end

	// Set wins over a clear that lands in the same cycle
	function automatic logic flag_next(input logic cur, input logic hw_set,
		input logic sw_clr);
		return hw_set | (cur & ~sw_clr);
	endfunction

	// Positions owned by the named flags; the rest only latch
	function automatic logic [FLAG_W-1:0] named_mask();
		logic [FLAG_W-1:0] m;
		m = '0;
		for (int i = 0; i <= icr_pkg::BIT_GEN_CALL; i++) begin
			m[i] = 1'b1;
		end
		return m;
	endfunction
	localparam logic [FLAG_W-1:0] SPARE_MASK = ~named_mask();

	// Receive underflow, cleared by its own read or clear-all
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			rx_under_flag <=
				icr_pkg::FLAGS_RESET[icr_pkg::BIT_RX_UNDER];
		else
			rx_under_flag <= flag_next(rx_under_flag,
				flag_set_in[icr_pkg::BIT_RX_UNDER],
				clr_mask[icr_pkg::BIT_RX_UNDER]);  // RL3
	end

	// Receive overflow, cleared by its own read or clear-all
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			rx_over_flag <=
				icr_pkg::FLAGS_RESET[icr_pkg::BIT_RX_OVER];
		else
			rx_over_flag <= flag_next(rx_over_flag,
				flag_set_in[icr_pkg::BIT_RX_OVER],
				clr_mask[icr_pkg::BIT_RX_OVER]);  // RL4
	end

	// Transmit overflow, cleared by its own read or clear-all
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			tx_over_flag <=
				icr_pkg::FLAGS_RESET[icr_pkg::BIT_TX_OVER];
		else
			tx_over_flag <= flag_next(tx_over_flag,
				flag_set_in[icr_pkg::BIT_TX_OVER],
				clr_mask[icr_pkg::BIT_TX_OVER]);  // RL5
	end

	// Slave read request; the bus waits until software serves it
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			read_req_flag <=
				icr_pkg::FLAGS_RESET[icr_pkg::BIT_RD_REQ];
		else
			read_req_flag <= flag_next(read_req_flag,
				flag_set_in[icr_pkg::BIT_RD_REQ],
				clr_mask[icr_pkg::BIT_RD_REQ]);  // RL6
	end

	// Transmit abort, cleared by the abort read or clear-all
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			transmit_abort_flag <=
				icr_pkg::FLAGS_RESET[icr_pkg::BIT_TX_ABORT];
		else
			transmit_abort_flag <= flag_next(transmit_abort_flag,
				flag_set_in[icr_pkg::BIT_TX_ABORT],
				clr_mask[icr_pkg::BIT_TX_ABORT]);  // RL7
	end

	// Receive done, cleared by its own read or clear-all
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			rx_done_flag <=
				icr_pkg::FLAGS_RESET[icr_pkg::BIT_RX_DONE];
		else
			rx_done_flag <= flag_next(rx_done_flag,
				flag_set_in[icr_pkg::BIT_RX_DONE],
				clr_mask[icr_pkg::BIT_RX_DONE]);  // RL9
	end

	// Stop detected, cleared by its own read or clear-all
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			stop_detected_flag <=
				icr_pkg::FLAGS_RESET[icr_pkg::BIT_STOP];
		else
			stop_detected_flag <= flag_next(stop_detected_flag,
				flag_set_in[icr_pkg::BIT_STOP],
				clr_mask[icr_pkg::BIT_STOP]);  // RL15
	end

	// Start seen; its own clear register lies outside this set
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			start_seen_flag <=
				icr_pkg::FLAGS_RESET[icr_pkg::BIT_START];
		else
			start_seen_flag <= flag_next(start_seen_flag,
				flag_set_in[icr_pkg::BIT_START],
				clr_mask[icr_pkg::BIT_START]);  // RL1
	end

	// General call; only clear-all reaches it from here
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			general_call_flag <=
				icr_pkg::FLAGS_RESET[icr_pkg::BIT_GEN_CALL];
		else
			general_call_flag <= flag_next(general_call_flag,
				flag_set_in[icr_pkg::BIT_GEN_CALL],
				clr_mask[icr_pkg::BIT_GEN_CALL]);  // RL1
	end

	// Receive threshold flag follows its level; no read clears it
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			rx_full_flag <=
				icr_pkg::FLAGS_RESET[icr_pkg::BIT_RX_FULL];
		else
			rx_full_flag <= rx_full_level_in;  // RL2
	end

	// Transmit threshold flag follows its level; no read clears it
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			tx_empty_flag <=
				icr_pkg::FLAGS_RESET[icr_pkg::BIT_TX_EMPTY];
		else
			tx_empty_flag <= tx_empty_level_in;  // RL2
	end

	// Busy self-clears once disabled and idle; a set still wins
	assign busy_self_clear = !ctrl_enable_in && busy_idle;  // RL12
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			bus_busy_flag <=
				icr_pkg::FLAGS_RESET[icr_pkg::BIT_BUSY];
		else
			bus_busy_flag <= flag_next(bus_busy_flag,
				flag_set_in[icr_pkg::BIT_BUSY],
				clr_mask[icr_pkg::BIT_BUSY] | busy_self_clear);  // RL12
	end

	// Unnamed upper flags only latch; no register clears them
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			spare_flags <= icr_pkg::FLAGS_RESET[FLAG_W-1:0] & SPARE_MASK;
		else
			spare_flags <= (spare_flags | flag_set_in) & SPARE_MASK;
	end

	// Raw status word gathered from the per-flag flops
	always_comb begin
		flags = spare_flags;
		flags[icr_pkg::BIT_RX_UNDER] = rx_under_flag;
		flags[icr_pkg::BIT_RX_OVER]  = rx_over_flag;
		flags[icr_pkg::BIT_RX_FULL]  = rx_full_flag;
		flags[icr_pkg::BIT_TX_OVER]  = tx_over_flag;
		flags[icr_pkg::BIT_TX_EMPTY] = tx_empty_flag;
		flags[icr_pkg::BIT_RD_REQ]   = read_req_flag;
		flags[icr_pkg::BIT_TX_ABORT] = transmit_abort_flag;
		flags[icr_pkg::BIT_RX_DONE]  = rx_done_flag;
		flags[icr_pkg::BIT_BUSY]     = bus_busy_flag;
		flags[icr_pkg::BIT_STOP]     = stop_detected_flag;
		flags[icr_pkg::BIT_START]    = start_seen_flag;
		flags[icr_pkg::BIT_GEN_CALL] = general_call_flag;
	end

	// Cause clear keeps the protected bit while it is set
	always_comb begin
		next_cause = cause;
		if (cause_clear) begin
			next_cause = '0;  // RL1 RL7
			next_cause[icr_pkg::BIT_CAUSE_KEEP] =
				cause[icr_pkg::BIT_CAUSE_KEEP];  // RL7
		end
		next_cause = next_cause | abort_cause_set_in;
	end

	// Abort cause flops
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			cause <= icr_pkg::CAUSE_RESET[CAUSE_W-1:0];
		else
			cause <= next_cause;
	end

	// Flush held from abort until the abort clear or clear-all read
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			flush_hold <= 1'b0;
		else if (flag_set_in[icr_pkg::BIT_TX_ABORT])
			flush_hold <= 1'b1;  // RL14
		else if (sel == icr_pkg::ICR_SEL_TXA || sel == icr_pkg::ICR_SEL_ALL)
			flush_hold <= 1'b0;  // RL8
	end

	// Value returned in bit 0 for the selected register
	always_comb begin
		case (sel)
			icr_pkg::ICR_SEL_ALL:  rd_bit = |(flags & ~bit_of(
				icr_pkg::BIT_RX_FULL) & ~bit_of(icr_pkg::BIT_TX_EMPTY));
			icr_pkg::ICR_SEL_RXU:  rd_bit = flags[icr_pkg::BIT_RX_UNDER];
			icr_pkg::ICR_SEL_RXO:  rd_bit = flags[icr_pkg::BIT_RX_OVER];
			icr_pkg::ICR_SEL_TXO:  rd_bit = flags[icr_pkg::BIT_TX_OVER];
			icr_pkg::ICR_SEL_RDQ:  rd_bit = flags[icr_pkg::BIT_RD_REQ];
			icr_pkg::ICR_SEL_TXA:  rd_bit = flags[icr_pkg::BIT_TX_ABORT];
			icr_pkg::ICR_SEL_RXD:  rd_bit = flags[icr_pkg::BIT_RX_DONE];
			icr_pkg::ICR_SEL_BUSY: rd_bit = flags[icr_pkg::BIT_BUSY];  // RL13
			icr_pkg::ICR_SEL_STOP: rd_bit = flags[icr_pkg::BIT_STOP];
			default:               rd_bit = 1'b0;
		endcase
	end

	// Read data registered; upper bits always zero
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			rdata_out <= icr_pkg::READ_ZERO;
		else
			rdata_out <= {15'h0000, rd_bit};  // RL16
	end

	// Combined output is any raw status flag, level-following threshold flags included
	assign combined_irq_out         = |flags;
	assign raw_interrupt_status_out = flags;
	assign transmit_abort_cause_out = cause;
	assign tx_fifo_flush_out        = flush_hold | ~ctrl_enable_in;
endmodule

// >>> rtl/icr_pkg.sv
// Constants for the interrupt clear register set of the bus controller
package icr_pkg;
	localparam int          ADDR_W          = 32;
	localparam int          DATA_W          = 16;
	localparam int          FLAG_W          = 16;
	localparam int          CAUSE_W         = 16;
	// Register byte addresses
	localparam logic [31:0] ADDR_CLEAR_ALL  = 32'h5000_1540;
	localparam logic [31:0] ADDR_CLR_RX_UND = 32'h5000_1544;
	localparam logic [31:0] ADDR_CLR_RX_OVR = 32'h5000_1548;
	localparam logic [31:0] ADDR_CLR_TX_OVR = 32'h5000_154c;
	localparam logic [31:0] ADDR_CLEAR_READ_REQUEST_READ = 32'h5000_1550;
	localparam logic [31:0] ADDR_CLR_TX_ABT = 32'h5000_1554;
	localparam logic [31:0] ADDR_CLR_RX_DON = 32'h5000_1558;
	localparam logic [31:0] ADDR_CLR_BUSY   = 32'h5000_155c;
	localparam logic [31:0] ADDR_CLR_STOP   = 32'h5000_1560;
	// Raw status bit positions
	localparam int          BIT_RX_UNDER    = 0;
	localparam int          BIT_RX_OVER     = 1;
	localparam int          BIT_RX_FULL     = 2;
	localparam int          BIT_TX_OVER     = 3;
	localparam int          BIT_TX_EMPTY    = 4;
	localparam int          BIT_RD_REQ      = 5;
	localparam int          BIT_TX_ABORT    = 6;
	localparam int          BIT_RX_DONE     = 7;
	localparam int          BIT_BUSY        = 8;
	localparam int          BIT_STOP        = 9;
	localparam int          BIT_START       = 10;
	localparam int          BIT_GEN_CALL    = 11;
	// Cause bit that survives a clear while set
	localparam int          BIT_CAUSE_KEEP  = 9;
	// Flags cleared by software (threshold flags excluded)
	localparam logic [15:0] SW_CLEAR_MASK   = 16'h0feb;
	localparam logic [15:0] FLAGS_RESET     = 16'h0000;
	localparam logic [15:0] CAUSE_RESET     = 16'h0000;
	localparam logic [15:0] READ_ZERO       = 16'h0000;
	// Read decode selection codes
	typedef enum logic [3:0] {
		ICR_SEL_NONE  = 4'h0,
		ICR_SEL_ALL   = 4'h1,
		ICR_SEL_RXU   = 4'h2,
		ICR_SEL_RXO   = 4'h3,
		ICR_SEL_TXO   = 4'h4,
		ICR_SEL_RDQ   = 4'h5,
		ICR_SEL_TXA   = 4'h6,
		ICR_SEL_RXD   = 4'h7,
		ICR_SEL_BUSY  = 4'h8,
		ICR_SEL_STOP  = 4'h9
	} icr_sel_t;
endpackage

// >>> rtl/icr_decode.sv
// Address decoder for the clear register set
`timescale 1ns/1ns
module icr_decode (
	input  wire logic [31:0]       addr_in,
	input  wire logic              read_in,
	output icr_pkg::icr_sel_t      sel_out
);
	// Only reads select; writes never reach the clear logic
	always_comb begin
		sel_out = icr_pkg::ICR_SEL_NONE;
		if (read_in) begin
			case (addr_in)
				icr_pkg::ADDR_CLEAR_ALL:  sel_out = icr_pkg::ICR_SEL_ALL;
				icr_pkg::ADDR_CLR_RX_UND: sel_out = icr_pkg::ICR_SEL_RXU;
				icr_pkg::ADDR_CLR_RX_OVR: sel_out = icr_pkg::ICR_SEL_RXO;
				icr_pkg::ADDR_CLR_TX_OVR: sel_out = icr_pkg::ICR_SEL_TXO;
				icr_pkg::ADDR_CLEAR_READ_REQUEST_READ: sel_out = icr_pkg::ICR_SEL_RDQ;
				icr_pkg::ADDR_CLR_TX_ABT: sel_out = icr_pkg::ICR_SEL_TXA;
				icr_pkg::ADDR_CLR_RX_DON: sel_out = icr_pkg::ICR_SEL_RXD;
				icr_pkg::ADDR_CLR_BUSY:   sel_out = icr_pkg::ICR_SEL_BUSY;
				icr_pkg::ADDR_CLR_STOP:   sel_out = icr_pkg::ICR_SEL_STOP;
				default:                  sel_out = icr_pkg::ICR_SEL_NONE;
			endcase
		end
	end
endmodule

// >>> test/icr_checker.sv
// Concurrent checks on the clear register set ports
`timescale 1ns/1ns
module icr_checker (
	input wire logic        mclk_in,
	input wire logic        reset_n_in,
	input wire logic [31:0] addr_in,
	input wire logic        read_in,
	input wire logic [15:0] rdata_out,
	input wire logic [15:0] flag_set_in,
	input wire logic        rx_full_level_in,
	input wire logic [15:0] abort_cause_set_in,
	input wire logic        ctrl_enable_in,
	input wire logic        bus_active_in,
	input wire logic [15:0] raw_interrupt_status_out,
	input wire logic [15:0] transmit_abort_cause_out,
	input wire logic        tx_fifo_flush_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!reset_n_in);
	wire [15:0] st = raw_interrupt_status_out;
	logic [8:0] hit;
	// Read hit per register slot, four bytes apart
	always_comb begin
		for (int i = 0; i < 9; i++) begin
			hit[i] = read_in && addr_in == icr_pkg::ADDR_CLEAR_ALL + 4 * i;
		end
	end
	chk_under_clear: assert property (hit[1] && !flag_set_in[0] |=> !st[0])
		else $error("underflow flag survived clear");
	chk_abort_release: assert property (hit[5] && !flag_set_in[6] |=>
		!st[6] && tx_fifo_flush_out == !ctrl_enable_in) else $error("abort clear");
	chk_all_clear: assert property (hit[0] && !flag_set_in &&
		!abort_cause_set_in && !bus_active_in |=> !(st & 16'h0feb) &&
		!(transmit_abort_cause_out & 16'hfdff)) else $error("clear-all missed");
	chk_all_spare: assert property (hit[0] && rx_full_level_in |=> st[2])
		else $error("threshold flag cleared");
	chk_busy_held: assert property ((hit[7] || hit[0]) && bus_active_in &&
		st[8] |=> st[8]) else $error("busy flag cleared while active");
	chk_busy_read: assert property (hit[7] |=>
		rdata_out == {15'h0, $past(st[8])}) else $error("busy read value");
	chk_busy_self: assert property (!ctrl_enable_in && !bus_active_in &&
		!flag_set_in[8] |=> !st[8]) else $error("busy not self-cleared");
	chk_stop_clear: assert property (hit[8] && !flag_set_in[9] |=> !st[9])
		else $error("stop flag survived clear");
	chk_idle_read: assert property (!read_in |=> rdata_out == 16'h0)
		else $error("data without read");
	cover property (hit[0] && rx_full_level_in);
	cover property (hit[7] && bus_active_in && st[8]);
	cover property (hit[5] && tx_fifo_flush_out);
endmodule

// >>> test/tb.sv
// Self-checking bench for the clear register set
`timescale 1ns/1ns
module tb;
	logic        mclk_in = 1'b0;
	logic        reset_n_in = 1'b0;
	logic [31:0] addr_in = 32'h0;
	logic        read_in = 1'b0;
	logic        write_in = 1'b0;
	logic [15:0] wdata_in = 16'h0;
	logic [15:0] rdata_out;
	logic [15:0] flag_set_in = 16'h0;
	logic        rx_full_level_in = 1'b0;
	logic        tx_empty_level_in = 1'b0;
	logic [15:0] abort_cause_set_in = 16'h0;
	logic        ctrl_enable_in = 1'b1;
	logic        bus_active_in = 1'b0;
	logic [15:0] raw_interrupt_status_out;
	logic [15:0] transmit_abort_cause_out;
	logic        combined_irq_out;
	logic        tx_fifo_flush_out;
	logic [15:0] d;
	int          errors = 0;
	int          n_compared = 0;
	int          cyc = 0;
	int          rb[9] = '{0, 0, 1, 3, 5, 6, 7, 8, 9};
	always #5 mclk_in = ~mclk_in;
	icr_clear_regs icr_clear_regs_inst (.mclk_in, .reset_n_in, .addr_in,
		.read_in, .write_in, .wdata_in, .rdata_out, .flag_set_in,
		.rx_full_level_in, .tx_empty_level_in, .abort_cause_set_in,
		.ctrl_enable_in, .bus_active_in, .raw_interrupt_status_out,
		.transmit_abort_cause_out, .combined_irq_out, .tx_fifo_flush_out);
	task automatic conclude();
		$display("errors=%0d compared=%0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Read one slot; data taken a half cycle after the answering edge
	task automatic rd(input int k);
		@(negedge mclk_in);
		read_in = 1'b1;
		addr_in = icr_pkg::ADDR_CLEAR_ALL + 4 * k;
		@(negedge mclk_in);
		d = rdata_out;
		read_in = 1'b0;
	endtask
	task automatic pulse(input logic [15:0] f, input logic [15:0] c);
		@(negedge mclk_in);
		flag_set_in = f;
		abort_cause_set_in = c;
		@(negedge mclk_in);
		flag_set_in = 16'h0;
		abort_cause_set_in = 16'h0;
	endtask
	task automatic t_single();
		for (int k = 1; k < 9; k++) begin
			if (k == 5 || k == 7) continue;
			pulse(16'h0800 | (16'h1 << rb[k]), 16'h0);
			rd(k);
			cmp(d, 16'h1);
			cmp(raw_interrupt_status_out, 16'h0800);
		end
	endtask
	// Abort flushes the FIFO; a write to the clear register must not help
	task automatic t_abort();
		pulse(16'h0040, 16'h0201);
		cmp(tx_fifo_flush_out, 1'b1);
		@(negedge mclk_in);
		write_in = 1'b1;
		addr_in = icr_pkg::ADDR_CLR_TX_ABT;
		wdata_in = 16'hffff;
		@(negedge mclk_in);
		write_in = 1'b0;
		cmp(tx_fifo_flush_out, 16'h1);
		cmp(raw_interrupt_status_out, 16'h0840);
		rd(5);
		cmp(d, 16'h1);
		cmp(transmit_abort_cause_out, 16'h0200);
		cmp(tx_fifo_flush_out, 16'h0);
		cmp(raw_interrupt_status_out, 16'h0800);
		rd(0);
		cmp(d, 16'h1);
		cmp(raw_interrupt_status_out, 16'h0);
		cmp(combined_irq_out, 16'h0);
		cmp(transmit_abort_cause_out, 16'h0200);
	endtask
	task automatic t_busy();
		bus_active_in = 1'b1;
		pulse(16'h0100, 16'h0);
		rd(7);
		cmp(d, 16'h1);
		rd(0);
		cmp(raw_interrupt_status_out, 16'h0100);
		bus_active_in = 1'b0;
		rd(7);
		cmp(d, 16'h1);
		cmp(raw_interrupt_status_out, 16'h0);
		pulse(16'h0100, 16'h0);
		cmp(raw_interrupt_status_out, 16'h0100);
		ctrl_enable_in = 1'b0;
		@(negedge mclk_in);
		cmp(raw_interrupt_status_out, 16'h0);
		ctrl_enable_in = 1'b1;
	endtask
	task automatic t_all();
		rx_full_level_in = 1'b1;
		tx_empty_level_in = 1'b1;
		pulse(16'h0feb, 16'h00ff);
		rd(0);
		cmp(d, 16'h1);
		cmp(combined_irq_out, 16'h1);
		cmp(raw_interrupt_status_out, 16'h0014);
		cmp(transmit_abort_cause_out, 16'h0200);
		rd(11);
		cmp(d, 16'h0);
	endtask
	initial begin
		repeat (6) @(posedge mclk_in);
		@(negedge mclk_in);
		reset_n_in = 1'b1;
		for (int k = 0; k < 9; k++) begin
			rd(k);
			cmp(d | raw_interrupt_status_out, 16'h0);
		end
		t_single();
		t_abort();
		t_busy();
		t_all();
		conclude();
	end
	// Run is under a hundred cycles; a hang is cut off well past that
	always @(posedge mclk_in) begin
		cyc++;
		if (cyc == 3000) begin
			errors++;
			conclude();
		end
	end
endmodule
bind icr_clear_regs icr_checker icr_checker_inst (.mclk_in, .reset_n_in,
	.addr_in, .read_in, .rdata_out, .flag_set_in, .rx_full_level_in,
	.abort_cause_set_in, .ctrl_enable_in, .bus_active_in,
	.raw_interrupt_status_out, .transmit_abort_cause_out, .tx_fifo_flush_out);
